/* File: inc/fbui_pkg.sv */
// Package for the flash block user interface: widths, encodings, status codes, timing.
// Assumes a single 100 MHz clock shared by the flash block and the fabric controller.
package fbui_pkg;
  localparam int ADDR_W          = 18;
  localparam int DATA_W          = 32;
  localparam int PAGE_BYTES      = 128;
  localparam int PAGE_OFS_W      = 7;
  localparam int NUM_PAGES       = 16;
  localparam int PAGE_IDX_W      = 4;
  // Transfer width encodings.
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  // Status codes.
  localparam logic [1:0] ST_OK       = 2'h0;
  localparam logic [1:0] ST_SINGLE   = 2'h1;
  localparam logic [1:0] ST_DOUBLE   = 2'h2;
  localparam logic [1:0] ST_REFUSED  = 2'h3;
  // Page status word fields.
  localparam int PS_COUNT_LSB    = 8;
  localparam int PS_OVERTHR_BIT  = 3;
  localparam int PS_RDPROT_BIT   = 2;
  localparam int PS_WRPROT_BIT   = 1;
  localparam int PS_OWPROT_BIT   = 0;
  localparam logic [23:0] OVER_THRESHOLD = 24'h000100;
  // Array operation time in nanoseconds, rounded up to whole cycles; real flash is far longer.
  localparam int ARRAY_OP_NS     = 100;
  localparam int CLK_NS          = 10;
  localparam int ARRAY_OP_CYC    = (ARRAY_OP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W           = 8;
endpackage

/* File: inc/fbui_if.sv */
// Interface joining the fabric controller and the flash block user port.
// Assumes both ends run on the same clock given to the interface.
`timescale 1ns/1ps
`default_nettype none
interface fbui_if (
  input wire logic CLK,
  input wire logic RST_N
);
  logic [17:0] addr;
  logic [1:0]  transfer_width_select;
  logic [31:0] write_data_in;
  logic [31:0] read_data;
  logic        aux_block_select;
  logic        spare_page_select;
  logic        read_req;
  logic        sequential_read_select;
  logic        page_info_select;
  logic        write_req;
  logic        program_req;
  logic        page_replace_request;
  logic        write_lock_on_program;
  logic        page_clear_request;
  logic        buffer_loss_guard;
  logic        page_unlock_request;
  logic        buffer_drop_request;
  logic        fabric_ownership_request;
  logic        pipe;
  logic        busy;
  logic [1:0]  status;

  modport flash (
    input  CLK, RST_N, addr, transfer_width_select, write_data_in, aux_block_select,
           spare_page_select, read_req, sequential_read_select, page_info_select, write_req,
           program_req, page_replace_request, write_lock_on_program, page_clear_request,
           buffer_loss_guard, page_unlock_request, buffer_drop_request,
           fabric_ownership_request, pipe,
    output read_data, busy, status
  );
  modport fabric (
    input  CLK, RST_N, read_data, busy, status,
    output addr, transfer_width_select, write_data_in, aux_block_select,
           spare_page_select, read_req, sequential_read_select, page_info_select, write_req,
           program_req, page_replace_request, write_lock_on_program, page_clear_request,
           buffer_loss_guard, page_unlock_request, buffer_drop_request,
           fabric_ownership_request, pipe
  );
endinterface
`default_nettype wire

/* File: logic/fbui_lane_sel.sv */
// Lane selector: places bytes of a word by transfer width and byte offset.
// Assumes little-endian byte order inside a 32-bit word.
`timescale 1ns/1ps
`default_nettype none
module fbui_lane_sel (
  input  wire logic [1:0]  width,
  input  wire logic [1:0]  ofs,
  input  wire logic [31:0] word_in,
  output logic      [31:0] data_out
);
  wire [31:0] shifted = word_in >> {ofs, 3'h0};

  assign data_out = (width == fbui_pkg::WIDTH_BYTE) ? {24'h000000, shifted[7:0]} :
                    (width == fbui_pkg::WIDTH_HALF) ? {16'h0000, shifted[15:0]} :
                    word_in;
endmodule
`default_nettype wire

/* File: logic/fbui_flash.sv */
// Behavioural flash block: page array, page buffer, status words and the request engine.
// Assumes requests are one-cycle pulses taken only while busy is low.
// Contract
// - Everything sampled on rising CLK edge; RST_N acts asynchronously.
// - Low reset returns engine to idle.
// - Fabric gives 18-bit byte address.
// - Width selects byte, half or word.
// - Aux and spare selects redirect access.
// - Busy high while operation runs.
// - Read data valid first non-busy cycle.
// - Read-next reads following word sequentially.
// - Page-info read returns page status word.
// - Read status 01 corrected, 10 uncorrected.
// - Status word: count high, reserved zero.
// - Bits: threshold, read, write, overwrite protect.
// - Program writes buffer into addressed page.
// - Replace writes page only if writable.
// - Write-lock program sets overwrite protect.
// - Clear programs page to zeros.
// - Guarded modified buffer blocks other pages; clears and reads of other pages still go through.
// - Fabric sets pipe above 50 MHz.
// - Unlock clears protection, copies page maybe.
// - Unlock reports 01, 10, or 11 refused.
// - Drop marks buffer unmodified, busy meanwhile.
// - Fabric asserts ownership while accessing.
//
`timescale 1ns/1ps
`default_nettype none
module fbui_flash #(
  parameter int NUM_PAGES = fbui_pkg::NUM_PAGES,
  parameter int OP_CYC    = fbui_pkg::ARRAY_OP_CYC
) (
  fbui_if.flash BUS
);
  localparam int WORDS = fbui_pkg::PAGE_BYTES / 4;
  localparam int WI_W  = fbui_pkg::PAGE_OFS_W - 2;

  typedef enum logic [2:0] {S_IDLE, S_ARRAY, S_OUT} fbui_state_t;

  // Array, buffer and per-page state; the spare and aux areas share the page index space.
  logic [31:0] array_mem [NUM_PAGES][WORDS];
  logic [31:0] buf_mem   [WORDS];
  logic [23:0] cycles_r  [NUM_PAGES];
  logic        owprot_r  [NUM_PAGES];
  logic        ecc_single_r [NUM_PAGES];
  logic        ecc_double_r [NUM_PAGES];

  fbui_state_t                        state_r;
  logic [fbui_pkg::CNT_W-1:0]         cnt_r;
  logic [fbui_pkg::PAGE_IDX_W-1:0]    buf_page_r;
  logic                               buf_valid_r;
  logic                               buf_mod_r;
  logic                               buf_guard_r;
  logic [fbui_pkg::PAGE_IDX_W-1:0]    op_page_r;
  logic [WI_W-1:0]                    op_word_r;
  logic [1:0]                         op_ofs_r;
  logic [1:0]                         op_width_r;
  logic [2:0]                         op_kind_r;
  logic [31:0]                        read_data_r;
  logic [31:0]                        pipe_r;
  logic [1:0]                         status_r;
  logic                               piped_r;

  localparam logic [2:0] K_READ = 3'h0, K_INFO = 3'h1, K_PROG = 3'h2, K_CLEAR = 3'h3;
  localparam logic [2:0] K_UNLOCK = 3'h4, K_DROP = 3'h5, K_NONE = 3'h6;

  wire [fbui_pkg::PAGE_IDX_W-1:0] base_page =
    BUS.addr[fbui_pkg::PAGE_OFS_W +: fbui_pkg::PAGE_IDX_W];
  wire [fbui_pkg::PAGE_IDX_W-1:0] req_page =
    BUS.spare_page_select ? {base_page[fbui_pkg::PAGE_IDX_W-1:1], 1'b1} :
    BUS.aux_block_select  ? (base_page ^ 4'h8) : base_page;
  wire [WI_W-1:0] req_word = BUS.addr[fbui_pkg::PAGE_OFS_W-1:2];
  wire            idle     = (state_r == S_IDLE);
  wire            other_pg = !buf_valid_r || (buf_page_r != req_page);
  wire            guard_hit = buf_mod_r && buf_guard_r && other_pg;
  wire            any_req  = BUS.read_req || BUS.program_req || BUS.page_replace_request ||
                             BUS.page_clear_request || BUS.page_unlock_request ||
                             BUS.buffer_drop_request || BUS.write_req;
  wire [WI_W-1:0] next_word = op_word_r + 5'h01;
  wire [23:0]     pcnt     = cycles_r[op_page_r];
  wire [31:0]     info_word = {pcnt, 4'h0, (pcnt >= fbui_pkg::OVER_THRESHOLD), 1'b0, 1'b0,
                               owprot_r[op_page_r]};
  wire [31:0]     lane_out;

  fbui_lane_sel u_lane (
    .width    (op_width_r),
    .ofs      (op_ofs_r),
    .word_in  ((op_kind_r == K_INFO) ? info_word :
               (buf_valid_r && buf_page_r == op_page_r) ? buf_mem[op_word_r] :
               array_mem[op_page_r][op_word_r]),
    .data_out (lane_out)
  );

  assign BUS.busy      = !idle;
  assign BUS.read_data = piped_r ? pipe_r : read_data_r;
  assign BUS.status    = status_r;

  always_ff @(posedge BUS.CLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      state_r     <= S_IDLE;
      cnt_r       <= '0;
      buf_page_r  <= '0;
      buf_valid_r <= 1'b0;
      buf_mod_r   <= 1'b0;
      buf_guard_r <= 1'b0;
      op_page_r   <= '0;
      op_word_r   <= '0;
      op_ofs_r    <= 2'h0;
      op_width_r  <= 2'h0;
      op_kind_r   <= K_NONE;
      read_data_r <= 32'h00000000;
      pipe_r      <= 32'h00000000;
      status_r    <= fbui_pkg::ST_OK;
      piped_r     <= 1'b0;
      for (int p = 0; p < NUM_PAGES; p++) begin
        cycles_r[p]     <= 24'h000000;
        owprot_r[p]     <= 1'b0;
        ecc_single_r[p] <= 1'b0;
        ecc_double_r[p] <= 1'b0;
      end
    end else begin
      // Extra output stage; it costs one cycle of latency in the busy window.
      pipe_r <= read_data_r;
      case (state_r)
        S_IDLE: begin
          if (any_req) begin
            state_r    <= S_ARRAY;
            cnt_r      <= 8'(OP_CYC);
            op_page_r  <= req_page;
            op_width_r <= BUS.transfer_width_select;
            op_ofs_r   <= BUS.addr[1:0];
            piped_r    <= BUS.pipe;
            status_r   <= fbui_pkg::ST_OK;
            op_kind_r  <= K_NONE;
            if (BUS.read_req && BUS.sequential_read_select) begin
              op_word_r <= next_word;
              op_kind_r <= K_READ;
            end else if (BUS.read_req) begin
              op_word_r <= req_word;
              op_kind_r <= BUS.page_info_select ? K_INFO : K_READ;
            end else if (BUS.buffer_drop_request) begin
              op_kind_r <= K_DROP;
            end else if (BUS.write_req) begin
              if (guard_hit) begin
                status_r <= fbui_pkg::ST_REFUSED;
              end else begin
                if (other_pg) begin
                  for (int w = 0; w < WORDS; w++) buf_mem[w] <= array_mem[req_page][w];
                end
                buf_mem[req_word] <= BUS.write_data_in;
                buf_page_r  <= req_page;
                buf_valid_r <= 1'b1;
                buf_mod_r   <= 1'b1;
                buf_guard_r <= BUS.buffer_loss_guard;
              end
            end else if (BUS.page_unlock_request) begin
              op_kind_r <= K_UNLOCK;
            end else if (BUS.page_clear_request) begin
              op_kind_r <= K_CLEAR;
            end else if (BUS.program_req || BUS.page_replace_request) begin
              if (owprot_r[req_page] || (guard_hit && buf_valid_r)) begin
                status_r <= fbui_pkg::ST_REFUSED;
              end else begin
                op_kind_r <= K_PROG;
              end
            end
          end
        end
        S_ARRAY: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            state_r <= piped_r ? S_OUT : S_IDLE;
            case (op_kind_r)
              K_READ: begin
                read_data_r <= lane_out;
                status_r <= ecc_double_r[op_page_r] ? fbui_pkg::ST_DOUBLE :
                            ecc_single_r[op_page_r] ? fbui_pkg::ST_SINGLE : fbui_pkg::ST_OK;
              end
              K_INFO: read_data_r <= lane_out;
              K_PROG: begin
                for (int w = 0; w < WORDS; w++) array_mem[op_page_r][w] <= buf_mem[w];
                cycles_r[op_page_r] <= cycles_r[op_page_r] + 24'h000001;
                owprot_r[op_page_r] <= BUS.write_lock_on_program;
                buf_mod_r <= 1'b0;
              end
              K_CLEAR: begin
                for (int w = 0; w < WORDS; w++) array_mem[op_page_r][w] <= 32'h00000000;
                // Reads of a buffered page come from the buffer, so it must follow the clear.
                if (buf_valid_r && buf_page_r == op_page_r) begin
                  for (int w = 0; w < WORDS; w++) buf_mem[w] <= 32'h00000000;
                end
                cycles_r[op_page_r] <= cycles_r[op_page_r] + 24'h000001;
              end
              K_UNLOCK: begin
                if (buf_mod_r && buf_guard_r && (buf_page_r != op_page_r || !buf_valid_r)) begin
                  status_r <= fbui_pkg::ST_REFUSED;
                end else begin
                  owprot_r[op_page_r] <= 1'b0;
                  if (!buf_valid_r || buf_page_r != op_page_r) begin
                    for (int w = 0; w < WORDS; w++) buf_mem[w] <= array_mem[op_page_r][w];
                    buf_page_r  <= op_page_r;
                    buf_valid_r <= 1'b1;
                    buf_mod_r   <= 1'b0;
                    status_r <= ecc_double_r[op_page_r] ? fbui_pkg::ST_DOUBLE :
                                ecc_single_r[op_page_r] ? fbui_pkg::ST_SINGLE :
                                fbui_pkg::ST_OK;
                  end
                end
              end
              K_DROP: buf_mod_r <= 1'b0;
              default: ;
            endcase
          end
        end
        S_OUT: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: logic/fbui_fabric.sv */
// Fabric-side flash controller: turns one-cycle user commands into block requests.
// Assumes the user issues a command only while USER_BUSY is low.
`timescale 1ns/1ps
`default_nettype none
module fbui_fabric #(
  parameter bit FAST_CLOCK = 1'b1
) (
  fbui_if.fabric     BUS,
  input  wire logic        USER_GO,
  input  wire logic [3:0]  USER_OP,
  input  wire logic [17:0] USER_ADDR,
  input  wire logic [1:0]  USER_WIDTH,
  input  wire logic [31:0] USER_WDATA,
  input  wire logic        USER_AUX,
  input  wire logic        USER_SPARE,
  input  wire logic        USER_LOCK,
  input  wire logic        USER_GUARD,
  output logic             USER_BUSY,
  output logic             USER_DONE,
  output logic      [31:0] USER_RDATA,
  output logic      [1:0]  USER_STATUS
);
  // Command codes on USER_OP.
  localparam logic [3:0] OP_READ = 4'h0, OP_NEXT = 4'h1, OP_INFO = 4'h2, OP_WRITE = 4'h3;
  localparam logic [3:0] OP_PROG = 4'h4, OP_REPL = 4'h5, OP_CLEAR = 4'h6, OP_UNLOCK = 4'h7;
  localparam logic [3:0] OP_DROP = 4'h8;

  logic        go_r;
  logic [3:0]  op_r;
  logic        wait_r;
  logic        own_r;
  logic [31:0] rdata_r;
  logic [1:0]  stat_r;
  logic        done_r;

  assign BUS.addr                   = USER_ADDR;
  assign BUS.transfer_width_select  = USER_WIDTH;
  assign BUS.write_data_in          = USER_WDATA;
  assign BUS.aux_block_select       = USER_AUX;
  assign BUS.spare_page_select      = USER_SPARE;
  assign BUS.write_lock_on_program  = USER_LOCK;
  assign BUS.buffer_loss_guard      = USER_GUARD;
  assign BUS.pipe                   = FAST_CLOCK;
  assign BUS.fabric_ownership_request = own_r;
  // Requests are single-cycle pulses launched from registers.
  // clear changes on clock.
  assign BUS.read_req               = go_r && (op_r == OP_READ || op_r == OP_NEXT ||
                                               op_r == OP_INFO);
  assign BUS.sequential_read_select = go_r && (op_r == OP_NEXT);
  assign BUS.page_info_select       = go_r && (op_r == OP_INFO);
  assign BUS.write_req              = go_r && (op_r == OP_WRITE);
  assign BUS.program_req            = go_r && (op_r == OP_PROG);
  assign BUS.page_replace_request   = go_r && (op_r == OP_REPL);
  assign BUS.page_clear_request     = go_r && (op_r == OP_CLEAR);
  assign BUS.page_unlock_request    = go_r && (op_r == OP_UNLOCK);
  assign BUS.buffer_drop_request    = go_r && (op_r == OP_DROP);
  assign USER_BUSY   = go_r || wait_r;
  assign USER_DONE   = done_r;
  assign USER_RDATA  = rdata_r;
  assign USER_STATUS = stat_r;

  always_ff @(posedge BUS.CLK or negedge BUS.RST_N) begin
    if (!BUS.RST_N) begin
      go_r    <= 1'b0;
      op_r    <= 4'h0;
      wait_r  <= 1'b0;
      own_r   <= 1'b0;
      rdata_r <= 32'h00000000;
      stat_r  <= 2'h0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      go_r   <= USER_GO && !go_r && !wait_r;
      if (USER_GO && !go_r && !wait_r) begin
        op_r  <= USER_OP;
        own_r <= 1'b1;
      end
      if (go_r) begin
        wait_r <= 1'b1;
      end else if (wait_r && !BUS.busy) begin
        wait_r  <= 1'b0;
        own_r   <= 1'b0;
        done_r  <= 1'b1;
        rdata_r <= BUS.read_data;
        stat_r  <= BUS.status;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/fbui_monitor.sv */
// Checker for the flash block user interface, fed with the interface signals.
// Assumes the default array time of ten cycles and one clock for both ends.
`timescale 1ns/1ps
`default_nettype none
module fbui_monitor (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [1:0]  transfer_width_select,
  input wire logic [31:0] read_data,
  input wire logic        read_req,
  input wire logic        sequential_read_select,
  input wire logic        page_info_select,
  input wire logic        write_req,
  input wire logic        program_req,
  input wire logic        page_replace_request,
  input wire logic        page_clear_request,
  input wire logic        page_unlock_request,
  input wire logic        buffer_drop_request,
  input wire logic        fabric_ownership_request,
  input wire logic        pipe,
  input wire logic        busy,
  input wire logic [1:0]  status
);
  wire logic any_req;
  wire logic rd_go;
  wire logic plain_rd;

  // Request decode; a read taken at an idle edge opens the read checks.
  assign any_req = read_req | write_req | program_req | page_replace_request
                 | page_clear_request | page_unlock_request | buffer_drop_request;
  assign rd_go = read_req & ~busy;
  assign plain_rd = rd_go & ~page_info_select;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // Read results are looked at twelve edges on, the first idle cycle with the extra stage.
  chk_reset_idle: assert property ($rose(RST_N) |-> !busy && status == fbui_pkg::ST_OK)
    else $error("flash not idle after reset");
  chk_busy_starts: assert property (any_req && !busy |=> busy)
    else $error("busy did not rise after a request");
  chk_read_span: assert property (rd_go && pipe |=> busy[*8] ##1 busy[*3] ##1 !busy)
    else $error("read busy span wrong");
  chk_idle_requests: assert property (busy |-> !any_req)
    else $error("request while busy");
  chk_owner_held: assert property (any_req |-> fabric_ownership_request)
    else $error("request without ownership");
  chk_pipe_fast: assert property (any_req |-> pipe)
    else $error("extra stage off at full rate");
  chk_byte_lane: assert property (plain_rd && transfer_width_select == fbui_pkg::WIDTH_BYTE
    |-> ##12 read_data[31:8] == 24'h0)
    else $error("byte read upper lanes not zero");
  chk_half_lane: assert property (plain_rd && transfer_width_select == fbui_pkg::WIDTH_HALF
    |-> ##12 read_data[31:16] == 16'h0)
    else $error("half read upper lanes not zero");
  chk_info_fields: assert property (rd_go && page_info_select
    |-> ##12 read_data[7:4] == 4'h0 && read_data[2:1] == 2'h0)
    else $error("page word reserved bits set");
  chk_read_status: assert property (plain_rd |-> ##12 status == fbui_pkg::ST_OK)
    else $error("read status flagged an error");
  chk_drop_span: assert property (buffer_drop_request && !busy
    |=> busy[*8] ##1 busy ##1 busy)
    else $error("drop ended early");

  // Main scenarios reached.
  cov_next_read: cover property (rd_go && sequential_read_select);
  cov_info_read: cover property (rd_go && page_info_select);
  cov_unlock: cover property (page_unlock_request && !busy);
  cov_drop: cover property (buffer_drop_request && !busy);
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Testbench: fabric controller and flash block joined by their interface.
// Drives the controller's user port with one command at a time and checks results.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        CLK;
  logic        RST_N;
  logic        go;
  logic [3:0]  op_c;
  logic [17:0] adr;
  logic [1:0]  wid;
  logic [31:0] wdat;
  logic        aux;
  logic        spare;
  logic        lock;
  logic        guard;
  logic        u_busy;
  logic        u_done;
  logic [31:0] u_rdata;
  logic [1:0]  u_status;
  logic [31:0] rd;
  logic [31:0] st;
  int          n_errors;
  int          cmp_count;
  int          cyc;

  fbui_if fbui_if_i (.CLK(CLK), .RST_N(RST_N));
  fbui_flash fbui_flash_i (.BUS(fbui_if_i));
  fbui_fabric #(.FAST_CLOCK(1'b1)) fbui_fabric_i (
    .BUS(fbui_if_i), .USER_GO(go), .USER_OP(op_c), .USER_ADDR(adr), .USER_WIDTH(wid),
    .USER_WDATA(wdat), .USER_AUX(aux), .USER_SPARE(spare), .USER_LOCK(lock),
    .USER_GUARD(guard), .USER_BUSY(u_busy), .USER_DONE(u_done), .USER_RDATA(u_rdata),
    .USER_STATUS(u_status));
  fbui_monitor fbui_monitor_i (
    .CLK(CLK), .RST_N(RST_N), .transfer_width_select(fbui_if_i.transfer_width_select),
    .read_data(fbui_if_i.read_data), .read_req(fbui_if_i.read_req),
    .sequential_read_select(fbui_if_i.sequential_read_select),
    .page_info_select(fbui_if_i.page_info_select), .write_req(fbui_if_i.write_req),
    .program_req(fbui_if_i.program_req), .page_replace_request(fbui_if_i.page_replace_request),
    .page_clear_request(fbui_if_i.page_clear_request),
    .page_unlock_request(fbui_if_i.page_unlock_request),
    .buffer_drop_request(fbui_if_i.buffer_drop_request),
    .fabric_ownership_request(fbui_if_i.fabric_ownership_request), .pipe(fbui_if_i.pipe),
    .busy(fbui_if_i.busy), .status(fbui_if_i.status));

  // Clock at 100 MHz.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One command: pulse go, then wait for done under a bound and keep its results.
  task automatic op(input logic [3:0] c, input logic [17:0] a, input logic [1:0] w,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    op_c <= c;
    adr <= a;
    wid <= w;
    wdat <= d;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    while (u_done !== 1'b1 && n < 100) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 100) begin
      n_errors++;
      $display("unexpected done missing expected 1 seen 0");
      report_and_stop();
    end
    rd = u_rdata;
    st = {30'h0, u_status};
  endtask

  // A hang is cut short well beyond the length of the sequence.
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    {go, op_c, adr, wid, wdat, aux, spare, lock, guard} = '0;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    RST_N = 1'b0;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    // Two words buffered and committed to page one, then read back by width.
    op(4'h3, 18'h00080, 2'h2, 32'h11223344);
    op(4'h3, 18'h00084, 2'h2, 32'h55667788);
    op(4'h4, 18'h00080, 2'h2, 32'h0);
    chk("program status", 32'h0, st);
    op(4'h0, 18'h00080, 2'h2, 32'h0);
    chk("word read", 32'h11223344, rd);
    op(4'h1, 18'h00080, 2'h2, 32'h0);
    chk("next read", 32'h55667788, rd);
    op(4'h0, 18'h00081, 2'h0, 32'h0);
    chk("byte read", 32'h00000033, rd);
    op(4'h0, 18'h00082, 2'h1, 32'h0);
    chk("half read", 32'h00001122, rd);
    op(4'h2, 18'h00080, 2'h2, 32'h0);
    chk("page word", 32'h00000100, rd);
    // Clearing writes zeros and counts a second cycle.
    op(4'h6, 18'h00080, 2'h2, 32'h0);
    op(4'h0, 18'h00080, 2'h2, 32'h0);
    chk("cleared read", 32'h0, rd);
    op(4'h2, 18'h00080, 2'h2, 32'h0);
    chk("page word cleared", 32'h00000200, rd);
    // A locked page refuses program and replace until unlocked.
    lock <= 1'b1;
    op(4'h3, 18'h00100, 2'h2, 32'hcafe0001);
    op(4'h4, 18'h00100, 2'h2, 32'h0);
    lock <= 1'b0;
    op(4'h2, 18'h00100, 2'h2, 32'h0);
    chk("locked page word", 32'h00000101, rd);
    op(4'h3, 18'h00100, 2'h2, 32'h00000bad);
    op(4'h4, 18'h00100, 2'h2, 32'h0);
    chk("locked program", 32'h3, st);
    op(4'h5, 18'h00100, 2'h2, 32'h0);
    chk("locked replace", 32'h3, st);
    // The page word shows no program landed: one cycle counted, still locked.
    op(4'h2, 18'h00100, 2'h2, 32'h0);
    chk("locked data", 32'h00000101, rd);
    op(4'h7, 18'h00100, 2'h2, 32'h0);
    chk("unlock status", 32'h0, st);
    op(4'h2, 18'h00100, 2'h2, 32'h0);
    chk("unlocked page word", 32'h00000100, rd);
    op(4'h3, 18'h00100, 2'h2, 32'h5a5a5a5a);
    op(4'h5, 18'h00100, 2'h2, 32'h0);
    op(4'h0, 18'h00100, 2'h2, 32'h0);
    chk("replaced data", 32'h5a5a5a5a, rd);
    // Aux and spare selects move the access; aux leaves the cleared page one apart, spare on page zero lands on it.
    aux <= 1'b1;
    op(4'h3, 18'h00080, 2'h2, 32'h0a0a0a0a);
    op(4'h4, 18'h00080, 2'h2, 32'h0);
    op(4'h0, 18'h00080, 2'h2, 32'h0);
    chk("aux read", 32'h0a0a0a0a, rd);
    aux <= 1'b0;
    op(4'h0, 18'h00080, 2'h2, 32'h0);
    chk("page one after aux", 32'h0, rd);
    spare <= 1'b1;
    op(4'h3, 18'h00000, 2'h2, 32'h0b0b0b0b);
    op(4'h4, 18'h00000, 2'h2, 32'h0);
    spare <= 1'b0;
    op(4'h0, 18'h00080, 2'h2, 32'h0);
    chk("spare read", 32'h0b0b0b0b, rd);
    // Guarded modified buffer blocks another page until dropped.
    guard <= 1'b1;
    op(4'h3, 18'h00180, 2'h2, 32'h00000001);
    op(4'h7, 18'h00200, 2'h2, 32'h0);
    chk("guarded unlock", 32'h3, st);
    op(4'h8, 18'h00180, 2'h2, 32'h0);
    chk("drop status", 32'h0, st);
    op(4'h7, 18'h00200, 2'h2, 32'h0);
    chk("unlock after drop", 32'h0, st);
    guard <= 1'b0;
    // Reset in mid-read brings both ends back to idle.
    @(posedge CLK);
    op_c <= 4'h0;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("busy in reset", 32'h0, {31'h0, fbui_if_i.busy});
    chk("user busy in reset", 32'h0, {31'h0, u_busy});
    RST_N <= 1'b1;
    op(4'h0, 18'h00100, 2'h2, 32'h0);
    chk("read after reset", 32'h5a5a5a5a, rd);
    report_and_stop();
  end
endmodule
`default_nettype wire
